// File: verilog/dsl_scramble_defect_monitor.sv
// Purpose: scrambler, descrambler, sync-loss and performance monitor
// Assumes: framer on mclk marks sync/unscrambled bits and frame ends
// Notes: power pin is asynchronous and is synchronised here
//
// Contract
// - sync and justification bits bypass scrambling
// - self-synchronising order-23 scrambler structure
// - customer-to-network taps 23 and 18
// - network-to-customer taps 23 and 5
// - receiver descrambles with transmitter polynomial
// - check mismatch gives per-frame check anomaly
// - repeater anomaly drives segment anomaly bit
// - plesiochronous: 3 bad frames set sync-loss
// - framing bits are sync and stuffing
// - plesiochronous: 2 clean frames clear sync-loss
// - synchronous: 3 anomaly frames set sync-loss
// - repeater sync-loss drives segment defect bit
// - segment defect clears when no repeater loss
// - failure after 2.5 s continuous defect
// - failure clears within 20 s absence
// - failure held at least 2 seconds
// - power loss sent in 3 frames minimum
// - errored second: any anomaly or defect
// - severe second: 50 anomalies or defect
// - unavailable second: failure during interval
// - one-second timer, 8-bit wrapping second counter
// - anomaly count, 15-minute and daily histories
// - segment anomaly bit zero on check errors
// - segment defect bit zero on sync loss
// - power status bit one when power normal
// - fixed 14-bit sync pattern checked
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module dsl_scramble_defect_monitor #(
   parameter int SEC_CYC = dsl_mon_pkg::SEC_CYCLES,
   parameter int FAIL_SET_CYC = dsl_mon_pkg::FAIL_SET_CYCLES,
   parameter int FAIL_HOLD_CYC = dsl_mon_pkg::FAIL_HOLD_CYCLES,
   parameter int FAIL_CLR_CYC = dsl_mon_pkg::FAIL_CLR_CYCLES,
   parameter int SECS_15MIN = dsl_mon_pkg::SEC_PER_15MIN,
   parameter int PERIODS_DAY = dsl_mon_pkg::PERIODS_PER_DAY
) (
   input wire logic mclk,
   input wire logic reset,
   input wire dsl_mon_pkg::line_bit_t tx_in,
   input wire logic tx_frame_start,
   output logic tx_bit_out,
   input wire dsl_mon_pkg::line_bit_t rx_in,
   input wire dsl_mon_pkg::rx_frame_t rx_frame,
   output logic rx_bit_out,
   output logic rx_bit_valid,
   input wire logic rep_check_anomaly,
   input wire logic rep_sync_loss,
   input wire logic power_ok_pin,
   output logic seg_anomaly_bit,
   output logic seg_defect_bit,
   output logic power_status_bit,
   output logic sync_loss_defect,
   output logic sync_loss_failure,
   input wire logic [9:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [31:0] rd_data
);
   import dsl_mon_pkg::*;

   function automatic logic scr_feedback(input logic [22:0] sr, input logic upstream);
      scr_feedback = sr[SCR_ORDER - 1] ^ (upstream ? sr[TAP_UPSTREAM - 1] : sr[TAP_DOWNSTREAM - 1]);
   endfunction

   logic [1:0] ctrl_reg;
   logic [22:0] tx_sr_reg, rx_sr_reg;
   logic tx_bit_reg, rx_bit_reg, rx_valid_reg;
   logic [3:0] sync_idx_reg;
   logic frame_bad_reg;
   logic [1:0] bad_cnt_reg, good_cnt_reg;
   logic defect_reg, fail_reg;
   logic [31:0] def_cnt_reg, abs_cnt_reg, hold_cnt_reg, sec_cyc_reg;
   logic sega_reg, segd_reg, ps_reg, pwr_meta_reg, pwr_sync_reg;
   logic [1:0] ps_frames_reg;
   logic [5:0] anom_sec_reg;
   logic def_sec_reg, fail_sec_reg;
   logic [7:0] err_sec_cnt_reg;
   logic [31:0] anom_count_reg;
   logic [9:0] sec15_reg, es15_reg, ses15_reg, uas15_reg;
   logic [6:0] per_day_reg;
   logic [16:0] es24_reg, ses24_reg, uas24_reg;
   logic [4:0] p15_reg;
   logic [2:0] p24_reg;
   logic [29:0] h15_mem [0:HIST15_DEPTH - 1];
   logic [50:0] h24_mem [0:HIST24_DEPTH];
   logic [31:0] rd_data_reg;

   // direction of each path follows which terminal this is
   wire network_side = ctrl_reg[CTRL_NETWORK_SIDE];
   wire sync_mode = ctrl_reg[CTRL_SYNC_MODE];
   wire tx_upstream = !network_side;
   wire rx_upstream = network_side;
   wire tx_scr = tx_in.data ^ scr_feedback(tx_sr_reg, tx_upstream);
   wire rx_dscr = rx_in.data ^ scr_feedback(rx_sr_reg, rx_upstream);
   wire sync_bit_bad = rx_in.valid && rx_in.sync &&
      (rx_in.data != SYNC_PATTERN[4'(SYNC_LEN - 1) - sync_idx_reg]);
   wire check_anom = rx_frame.frame_end && (rx_frame.check_calc != rx_frame.check_recv);
   wire frame_framing_bad = frame_bad_reg || sync_bit_bad || rx_frame.stuff_err;
   wire frame_bad = sync_mode ? check_anom : frame_framing_bad;
   wire sec_tick = (sec_cyc_reg == 32'(SEC_CYC - 1));
   wire es_now = (anom_sec_reg != 6'h00) || def_sec_reg;
   wire ses_now = (anom_sec_reg >= SES_ANOM_MIN) || def_sec_reg;
   wire uas_now = fail_sec_reg;
   wire end15 = sec_tick && (sec15_reg == 10'(SECS_15MIN - 1));
   wire end24 = end15 && (per_day_reg == 7'(PERIODS_DAY - 1));
   wire [9:0] es15_next = es15_reg + {9'h000, es_now};
   wire [9:0] ses15_next = ses15_reg + {9'h000, ses_now};
   wire [9:0] uas15_next = uas15_reg + {9'h000, uas_now};
   wire [16:0] es24_next = es24_reg + {16'h0000, es_now};
   wire [16:0] ses24_next = ses24_reg + {16'h0000, ses_now};
   wire [16:0] uas24_next = uas24_reg + {16'h0000, uas_now};
   wire [4:0] h15_idx = p15_reg - 5'h01 - addr[6:2];
   wire [2:0] h24_idx = p24_reg - 3'h1 - addr[4:2];
   wire [50:0] h24_word = h24_mem[h24_idx];
   wire in_h15 = (addr[9:7] == REG_HIST15_BASE[9:7]);
   wire in_h24 = (addr[4:2] < 3'(HIST24_DEPTH));
   logic [31:0] rd_next;

   always_comb begin
      rd_next = 32'h0000_0000;
      if (in_h15) begin
         rd_next = {2'h0, h15_mem[h15_idx]};
      end else begin
         case ({addr[9:5], 5'h00})
            REG_HIST24_ES: rd_next = in_h24 ? {15'h0000, h24_word[16:0]} : 32'h0000_0000;
            REG_HIST24_SES: rd_next = in_h24 ? {15'h0000, h24_word[33:17]} : 32'h0000_0000;
            REG_HIST24_UAS: rd_next = in_h24 ? {15'h0000, h24_word[50:34]} : 32'h0000_0000;
            default: begin
               case (addr)
                  REG_CTRL: rd_next = {30'h0000_0000, ctrl_reg};
                  REG_STATUS: rd_next = {26'h000_0000, ps_reg, segd_reg, sega_reg,
                     fail_reg, defect_reg, pwr_sync_reg};
                  REG_ANOM_COUNT: rd_next = anom_count_reg;
                  REG_ERR_SEC_COUNT: rd_next = {24'h00_0000, err_sec_cnt_reg};
                  REG_CUR15: rd_next = {2'h0, uas15_reg, ses15_reg, es15_reg};
                  REG_CUR24_ES: rd_next = {15'h0000, es24_reg};
                  REG_CUR24_SES: rd_next = {15'h0000, ses24_reg};
                  REG_CUR24_UAS: rd_next = {15'h0000, uas24_reg};
                  default: rd_next = 32'h0000_0000;
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_reg <= CTRL_RESET;
         rd_data_reg <= 32'h0000_0000;
      end else begin
         if (wr_strobe && addr == REG_CTRL) begin
            ctrl_reg <= wr_data[1:0];
         end
         rd_data_reg <= rd_strobe ? rd_next : 32'h0000_0000;
      end
   end

   // delay lines shift only on scrambled bits; tx line feeds on itself, so it is cleared
   always_ff @(posedge mclk) begin
      if (reset) begin
         tx_bit_reg <= 1'b0;
         rx_bit_reg <= 1'b0;
         rx_valid_reg <= 1'b0;
         tx_sr_reg <= 23'h000000;
      end else begin
         rx_valid_reg <= rx_in.valid;
         if (tx_in.valid && !tx_in.unscr) begin
            tx_sr_reg <= {tx_sr_reg[21:0], tx_scr};
         end
         if (tx_in.valid) begin
            tx_bit_reg <= tx_in.unscr ? tx_in.data : tx_scr;
         end
         if (rx_in.valid) begin
            rx_bit_reg <= rx_in.unscr ? rx_in.data : rx_dscr;
         end
      end
      if (rx_in.valid && !rx_in.unscr) begin
         rx_sr_reg <= {rx_sr_reg[21:0], rx_in.data};
      end
   end

   // sync-loss defect from framing or check errors per frame
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync_idx_reg <= 4'h0;
         frame_bad_reg <= 1'b0;
         bad_cnt_reg <= 2'h0;
         good_cnt_reg <= 2'h0;
         defect_reg <= 1'b0;
      end else if (rx_frame.frame_end) begin
         sync_idx_reg <= 4'h0;
         frame_bad_reg <= 1'b0;
         bad_cnt_reg <= frame_bad ? ((bad_cnt_reg == SYNC_LOSS_SET) ? bad_cnt_reg
            : bad_cnt_reg + 2'h1) : 2'h0;
         good_cnt_reg <= frame_bad ? 2'h0 : ((good_cnt_reg == SYNC_LOSS_CLR) ? good_cnt_reg
            : good_cnt_reg + 2'h1);
         if (frame_bad && bad_cnt_reg >= SYNC_LOSS_SET - 2'h1) begin
            defect_reg <= 1'b1;
         end else if (!frame_bad && good_cnt_reg >= SYNC_LOSS_CLR - 2'h1) begin
            defect_reg <= 1'b0;
         end
      end else begin
         if (rx_in.valid && rx_in.sync) begin
            sync_idx_reg <= sync_idx_reg + 4'h1;
         end
         frame_bad_reg <= frame_bad_reg || sync_bit_bad;
      end
   end

   // failure timing in cycles; hold timer gates any clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         fail_reg <= 1'b0;
         def_cnt_reg <= 32'h0000_0000;
         abs_cnt_reg <= 32'h0000_0000;
         hold_cnt_reg <= 32'h0000_0000;
      end else begin
         def_cnt_reg <= defect_reg ? def_cnt_reg + {31'h0000_0000, !fail_reg} : 32'h0000_0000;
         abs_cnt_reg <= defect_reg ? 32'h0000_0000 : abs_cnt_reg + {31'h0000_0000, fail_reg};
         hold_cnt_reg <= fail_reg ? hold_cnt_reg + {31'h0000_0000,
            hold_cnt_reg < 32'(FAIL_HOLD_CYC)} : 32'h0000_0000;
         if (!fail_reg && defect_reg && def_cnt_reg >= 32'(FAIL_SET_CYC - 1)) begin
            fail_reg <= 1'b1;
         end else if (fail_reg && !defect_reg && abs_cnt_reg >= 32'(FAIL_CLR_CYC - 1)
            && hold_cnt_reg >= 32'(FAIL_HOLD_CYC)) begin
            fail_reg <= 1'b0;
         end
      end
   end

   // indicator bits; power pin crosses in through two flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         sega_reg <= 1'b1;
         segd_reg <= 1'b1;
         ps_reg <= 1'b1;
         ps_frames_reg <= 2'h0;
         pwr_meta_reg <= 1'b1;
         pwr_sync_reg <= 1'b1;
      end else begin
         pwr_meta_reg <= power_ok_pin;
         pwr_sync_reg <= pwr_meta_reg;
         if (rx_frame.frame_end) begin
            sega_reg <= !(check_anom || rep_check_anomaly);
         end
         segd_reg <= !(defect_reg || rep_sync_loss);
         if (network_side) begin
            ps_reg <= 1'b1;
         end else if (!pwr_sync_reg) begin
            ps_reg <= 1'b0;
            ps_frames_reg <= 2'h0;
         end else if (!ps_reg && tx_frame_start) begin
            // return to one only after enough loss frames went out
            if (ps_frames_reg >= POWER_FRAMES - 2'h1) begin
               ps_reg <= 1'b1;
            end
            ps_frames_reg <= ps_frames_reg + 2'h1;
         end
      end
   end

   // one-second interval latches; an event in the tick cycle opens the next interval
   always_ff @(posedge mclk) begin
      if (reset) begin
         sec_cyc_reg <= 32'h0000_0000;
         anom_sec_reg <= 6'h00;
         def_sec_reg <= 1'b0;
         fail_sec_reg <= 1'b0;
         err_sec_cnt_reg <= 8'h00;
         anom_count_reg <= 32'h0000_0000;
      end else begin
         sec_cyc_reg <= sec_tick ? 32'h0000_0000 : sec_cyc_reg + 32'h0000_0001;
         anom_count_reg <= anom_count_reg + {31'h0000_0000, check_anom};
         if (sec_tick) begin
            anom_sec_reg <= {5'h00, check_anom};
            def_sec_reg <= defect_reg;
            fail_sec_reg <= fail_reg;
            err_sec_cnt_reg <= err_sec_cnt_reg + {7'h00, es_now || ses_now};
         end else begin
            if (check_anom && anom_sec_reg < SES_ANOM_MIN) begin
               anom_sec_reg <= anom_sec_reg + 6'h01;
            end
            def_sec_reg <= def_sec_reg || defect_reg;
            fail_sec_reg <= fail_sec_reg || fail_reg;
         end
      end
   end

   // period totals; histories are rings addressed newest first
   always_ff @(posedge mclk) begin
      if (reset) begin
         sec15_reg <= 10'h000;
         per_day_reg <= 7'h00;
         {es15_reg, ses15_reg, uas15_reg} <= 30'h0000_0000;
         {es24_reg, ses24_reg, uas24_reg} <= 51'h0_0000_0000_0000;
         p15_reg <= 5'h00;
         p24_reg <= 3'h0;
      end else if (sec_tick) begin
         sec15_reg <= end15 ? 10'h000 : sec15_reg + 10'h001;
         {es15_reg, ses15_reg, uas15_reg} <= end15 ? 30'h0000_0000
            : {es15_next, ses15_next, uas15_next};
         {es24_reg, ses24_reg, uas24_reg} <= end24 ? 51'h0_0000_0000_0000
            : {es24_next, ses24_next, uas24_next};
         if (end15) begin
            p15_reg <= p15_reg + 5'h01;
            per_day_reg <= end24 ? 7'h00 : per_day_reg + 7'h01;
         end
         if (end24) begin
            p24_reg <= (p24_reg == 3'(HIST24_DEPTH)) ? 3'h0 : p24_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset && end15) begin
         h15_mem[p15_reg] <= {uas15_next, ses15_next, es15_next};
      end
      if (!reset && end24) begin
         h24_mem[p24_reg] <= {uas24_next, ses24_next, es24_next};
      end
   end

   assign tx_bit_out = tx_bit_reg;
   assign rx_bit_out = rx_bit_reg;
   assign rx_bit_valid = rx_valid_reg;
   assign seg_anomaly_bit = sega_reg;
   assign seg_defect_bit = segd_reg;
   assign power_status_bit = ps_reg;
   assign sync_loss_defect = defect_reg;
   assign sync_loss_failure = fail_reg;
   assign rd_data = rd_data_reg;

   property p_bypass;
      @(posedge mclk) disable iff (reset)
      (tx_in.valid && tx_in.unscr) |=> (tx_bit_out == $past(tx_in.data)) && $stable(tx_sr_reg);
   endproperty
   a_bypass: assert property (p_bypass) else $error("unscrambled bit altered");

   property p_scr_shift;
      @(posedge mclk) disable iff (reset)
      (tx_in.valid && !tx_in.unscr) |=> (tx_sr_reg[0] == tx_bit_out) && (tx_sr_reg[22:1] == $past(tx_sr_reg[21:0]));
   endproperty
   a_scr_shift: assert property (p_scr_shift) else $error("scrambler line not fed by output");

   property p_anomaly_count;
      @(posedge mclk) disable iff (reset)
      check_anom |=> anom_count_reg == $past(anom_count_reg) + 32'h0000_0001;
   endproperty
   a_anomaly_count: assert property (p_anomaly_count) else $error("anomaly not counted");

   property p_loss_set;
      @(posedge mclk) disable iff (reset)
      (rx_frame.frame_end && frame_bad && bad_cnt_reg == 2'h2) |=> defect_reg;
   endproperty
   a_loss_set: assert property (p_loss_set) else $error("sync loss not declared");

   property p_loss_clear;
      @(posedge mclk) disable iff (reset)
      (rx_frame.frame_end && !frame_bad && good_cnt_reg == 2'h1) |=> !defect_reg;
   endproperty
   a_loss_clear: assert property (p_loss_clear) else $error("sync loss not cleared");

   property p_fail_rise;
      @(posedge mclk) disable iff (reset)
      $rose(fail_reg) |-> $past(defect_reg) && $past(def_cnt_reg) >= 32'(FAIL_SET_CYC - 1);
   endproperty
   a_fail_rise: assert property (p_fail_rise) else $error("failure raised early");

   property p_fail_hold;
      @(posedge mclk) disable iff (reset)
      $fell(fail_reg) |-> $past(hold_cnt_reg) >= 32'(FAIL_HOLD_CYC) && !$past(defect_reg);
   endproperty
   a_fail_hold: assert property (p_fail_hold) else $error("failure dropped too soon");

   property p_segd;
      @(posedge mclk) disable iff (reset)
      (defect_reg || rep_sync_loss) |=> !seg_defect_bit;
   endproperty
   a_segd: assert property (p_segd) else $error("segment defect bit not zero");

   property p_err_sec;
      @(posedge mclk) disable iff (reset)
      (sec_tick && def_sec_reg) |=> err_sec_cnt_reg == $past(err_sec_cnt_reg) + 8'h01;
   endproperty
   a_err_sec: assert property (p_err_sec) else $error("errored second missed");
endmodule

// File: common/dsl_mon_pkg.sv
// Purpose: shared constants and carriers for the line scrambler and defect monitor
// Assumes: 10 MHz mclk, one line bit per valid strobe
// Notes: first received sync bit is the msb of the sync pattern
package dsl_mon_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam longint NS_PER_MS = 64'h0000_0000_000F_4240;
   localparam int SEC_MS = 1000;
   localparam int FAIL_SET_MS = 2500;
   localparam int FAIL_HOLD_MS = 2000;
   // clears well inside the 20 s limit
   localparam int FAIL_CLR_MS = 10000;
   localparam int SEC_CYCLES = int'((SEC_MS * NS_PER_MS) / CLK_PERIOD_NS);
   localparam int FAIL_SET_CYCLES = int'((FAIL_SET_MS * NS_PER_MS) / CLK_PERIOD_NS);
   localparam int FAIL_HOLD_CYCLES = int'((FAIL_HOLD_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int FAIL_CLR_CYCLES = int'((FAIL_CLR_MS * NS_PER_MS) / CLK_PERIOD_NS);
   localparam int SEC_PER_15MIN = 900;
   localparam int PERIODS_PER_DAY = 96;
   localparam int SCR_ORDER = 23;
   localparam int TAP_UPSTREAM = 18;
   localparam int TAP_DOWNSTREAM = 5;
   localparam int SYNC_LEN = 14;
   localparam logic [13:0] SYNC_PATTERN = 14'h3F0C;
   localparam logic [1:0] SYNC_LOSS_SET = 2'h3;
   localparam logic [1:0] SYNC_LOSS_CLR = 2'h2;
   localparam logic [5:0] SES_ANOM_MIN = 6'h32;
   localparam logic [1:0] POWER_FRAMES = 2'h3;
   localparam int HIST15_DEPTH = 32;
   localparam int HIST24_DEPTH = 7;
   // register map, byte addresses
   localparam logic [9:0] REG_CTRL = 10'h000;
   localparam logic [9:0] REG_STATUS = 10'h004;
   localparam logic [9:0] REG_ANOM_COUNT = 10'h008;
   localparam logic [9:0] REG_ERR_SEC_COUNT = 10'h00C;
   localparam logic [9:0] REG_CUR15 = 10'h010;
   localparam logic [9:0] REG_CUR24_ES = 10'h014;
   localparam logic [9:0] REG_CUR24_SES = 10'h018;
   localparam logic [9:0] REG_CUR24_UAS = 10'h01C;
   localparam logic [9:0] REG_HIST15_BASE = 10'h100;
   localparam logic [9:0] REG_HIST24_ES = 10'h200;
   localparam logic [9:0] REG_HIST24_SES = 10'h220;
   localparam logic [9:0] REG_HIST24_UAS = 10'h240;
   localparam int CTRL_NETWORK_SIDE = 0;
   localparam int CTRL_SYNC_MODE = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   typedef struct packed {
      logic valid;
      logic unscr;
      logic sync;
      logic data;
   } line_bit_t;

   typedef struct packed {
      logic frame_end;
      logic stuff_err;
      logic [5:0] check_calc;
      logic [5:0] check_recv;
   } rx_frame_t;
endpackage

// File: test/peer_line_model.sv
// Purpose: far line end, scrambles toward the monitor, descrambles its output
// Assumes: taps set at run time, delay lines fed from line bits
// Notes: idle data line shows the inverse of the last bit sent
`timescale 1ns/1ns
module peer_line_model (
   input wire logic mclk,
   input wire logic [4:0] rx_tap,
   input wire logic [4:0] tx_tap,
   input wire dsl_mon_pkg::line_bit_t peer_in,
   output dsl_mon_pkg::line_bit_t line_out,
   input wire logic dut_bit,
   input wire logic dut_valid,
   output logic recovered
);
   import dsl_mon_pkg::*;
   logic [22:0] scr_reg = 23'h5A5A5A;
   logic [22:0] dscr_reg = 23'h000000;
   logic last_reg = 1'b0;
   logic take_reg = 1'b0;
   logic scr_bit;
   // bypass bits go out raw
   assign scr_bit = peer_in.unscr ? peer_in.data
      : peer_in.data ^ scr_reg[22] ^ scr_reg[rx_tap - 5'h01];
   assign line_out = peer_in.valid ? {1'b1, peer_in.unscr, peer_in.sync, scr_bit}
      : {3'h0, ~last_reg};
   assign recovered = dut_bit ^ dscr_reg[22] ^ dscr_reg[tx_tap - 5'h01];
   always_ff @(posedge mclk) begin
      take_reg <= dut_valid;
      if (peer_in.valid) begin
         last_reg <= scr_bit;
      end
      if (peer_in.valid && !peer_in.unscr) begin
         scr_reg <= {scr_reg[21:0], scr_bit};
      end
      if (take_reg) begin
         dscr_reg <= {dscr_reg[21:0], dut_bit};
      end
   end
endmodule

// File: test/tb_dsl_scramble_defect_monitor.sv
// Purpose: self-checking bench for the scrambler and defect monitor
// Assumes: short second and failure timers set by parameters
// Notes: scrambled bits judged only after 23 bits of warm-up
`timescale 1ns/1ns
module tb_dsl_scramble_defect_monitor;
   import dsl_mon_pkg::*;
   localparam int SEC = 100;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   line_bit_t tx_in = '0;
   line_bit_t peer_in = '0;
   line_bit_t rx_in;
   rx_frame_t rx_frame = '0;
   logic tx_frame_start = 1'b0;
   logic rep_check_anomaly = 1'b0;
   logic rep_sync_loss = 1'b0;
   logic power_ok_pin = 1'b1;
   logic [9:0] addr = '0;
   logic [31:0] wr_data = '0;
   logic wr_strobe = 1'b0;
   logic rd_strobe = 1'b0;
   logic tx_bit_out, rx_bit_out, rx_bit_valid, seg_anomaly_bit, seg_defect_bit;
   logic power_status_bit, sync_loss_defect, sync_loss_failure, recovered;
   logic [31:0] rd_data, word, base;
   logic [4:0] rx_tap = 5'h05;
   logic [4:0] tx_tap = 5'h12;
   logic [15:0] lfsr = 16'hD5ED;
   logic exp_tx [0:63];
   logic exp_rx [0:63];
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   dsl_scramble_defect_monitor #(.SEC_CYC(SEC), .FAIL_SET_CYC(250), .FAIL_HOLD_CYC(200),
      .FAIL_CLR_CYC(1000), .SECS_15MIN(4), .PERIODS_DAY(3)) DUT (.mclk(mclk), .reset(reset),
      .tx_in(tx_in), .tx_frame_start(tx_frame_start), .tx_bit_out(tx_bit_out), .rx_in(rx_in),
      .rx_frame(rx_frame), .rx_bit_out(rx_bit_out), .rx_bit_valid(rx_bit_valid),
      .rep_check_anomaly(rep_check_anomaly), .rep_sync_loss(rep_sync_loss),
      .power_ok_pin(power_ok_pin), .seg_anomaly_bit(seg_anomaly_bit),
      .seg_defect_bit(seg_defect_bit), .power_status_bit(power_status_bit),
      .sync_loss_defect(sync_loss_defect), .sync_loss_failure(sync_loss_failure),
      .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
      .rd_data(rd_data));
   peer_line_model PEER (.mclk(mclk), .rx_tap(rx_tap), .tx_tap(tx_tap), .peer_in(peer_in),
      .line_out(rx_in), .dut_bit(tx_bit_out), .dut_valid(tx_in.valid), .recovered(recovered));
   initial begin
      forever #50 mclk = ~mclk;
   end
   // whole run is near 2000 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 8000) begin
         mismatches++;
         stop_test();
      end
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %b got %b", what, exp, got);
      end
   endtask
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h got %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      if (mismatches == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge mclk);
      wr_strobe <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a);
      @(posedge mclk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge mclk);
      rd_strobe <= 1'b0;
      @(negedge mclk);
      word = rd_data;
   endtask
   task automatic frame(input logic stuff_bad, input logic chk_bad, input logic rep);
      @(posedge mclk);
      rep_check_anomaly <= rep;
      rx_frame <= {1'b1, stuff_bad, 6'h15, chk_bad ? 6'h2A : 6'h15};
      @(posedge mclk);
      rx_frame <= '0;
      @(negedge mclk);
   endtask
   task automatic stream(input logic unscr);
      for (int i = 0; i <= 60; i++) begin
         @(posedge mclk);
         lfsr = lfsr_next(lfsr);
         exp_tx[i] = lfsr[0];
         exp_rx[i] = lfsr[7];
         tx_in <= {i < 60, unscr, 1'b0, lfsr[0]};
         peer_in <= {i < 60, unscr, 1'b0, lfsr[7]};
         @(negedge mclk);
         if (i > 0 && (unscr || i > 23)) begin
            chk_bit("rx_bit_valid", 1'b1, rx_bit_valid);
            chk_bit("rx_bit_out", exp_rx[i-1], rx_bit_out);
            chk_bit("tx_line", exp_tx[i-1], unscr ? tx_bit_out : recovered);
         end
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      chk_word("flags", 32'h1C, {27'h0, seg_anomaly_bit, seg_defect_bit,
         power_status_bit, sync_loss_defect, sync_loss_failure});
      rd(REG_STATUS);
      chk_word("status", 32'h39, word);
      rd(10'h3FC);
      chk_word("unmapped", 32'h0, word);
      @(negedge mclk);
      chk_word("rd_data idle", 32'h0, rd_data);
      for (int m = 0; m < 2; m++) begin
         wr(REG_CTRL, 32'(m));
         rd(REG_CTRL);
         chk_word("ctrl", 32'(m), word);
         tx_tap = (m == 1) ? 5'h05 : 5'h12;
         rx_tap = (m == 1) ? 5'h12 : 5'h05;
         stream(1'b1);
         stream(1'b0);
      end
      wr(REG_CTRL, 32'h0);
      frame(1'b0, 1'b1, 1'b0);
      chk_bit("seg_anomaly_bit", 1'b0, seg_anomaly_bit);
      frame(1'b0, 1'b0, 1'b1);
      chk_bit("seg_anomaly_bit", 1'b0, seg_anomaly_bit);
      frame(1'b0, 1'b0, 1'b0);
      chk_bit("seg_anomaly_bit", 1'b1, seg_anomaly_bit);
      for (int k = 0; k < 3; k++) begin
         frame(1'b1, 1'b0, 1'b0);
         chk_bit("sync_loss_defect", k == 2, sync_loss_defect);
      end
      @(negedge mclk);
      chk_bit("seg_defect_bit", 1'b0, seg_defect_bit);
      n = 1;
      while (!sync_loss_failure && n < 320) begin
         @(negedge mclk);
         n++;
      end
      chk_bit("failure set time", 1'b1, n >= 200 && n <= 300);
      frame(1'b0, 1'b0, 1'b0);
      chk_bit("sync_loss_defect", 1'b1, sync_loss_defect);
      frame(1'b0, 1'b0, 1'b0);
      chk_bit("sync_loss_defect", 1'b0, sync_loss_defect);
      n = 0;
      while (sync_loss_failure && n < 2100) begin
         @(negedge mclk);
         n++;
      end
      chk_bit("failure clear time", 1'b1, n >= 196 && n <= 2000);
      chk_bit("seg_defect_bit", 1'b1, seg_defect_bit);
      @(posedge mclk);
      rep_sync_loss <= 1'b1;
      repeat (3) @(negedge mclk);
      chk_bit("seg_defect_bit", 1'b0, seg_defect_bit);
      @(posedge mclk);
      rep_sync_loss <= 1'b0;
      repeat (3) @(negedge mclk);
      chk_bit("seg_defect_bit", 1'b1, seg_defect_bit);
      wr(REG_CTRL, 32'h2);
      for (int k = 0; k < 3; k++) begin
         frame(1'b0, 1'b1, 1'b0);
         chk_bit("sync_loss_defect", k == 2, sync_loss_defect);
      end
      frame(1'b0, 1'b0, 1'b0);
      frame(1'b0, 1'b0, 1'b0);
      wr(REG_CTRL, 32'h0);
      // a quiet second first, so one anomaly gives exactly one errored second
      repeat (2 * SEC) @(posedge mclk);
      rd(REG_ERR_SEC_COUNT);
      base = word;
      rd(REG_ANOM_COUNT);
      n = int'(word);
      frame(1'b0, 1'b1, 1'b0);
      repeat (2 * SEC) @(posedge mclk);
      rd(REG_ERR_SEC_COUNT);
      chk_word("err_sec_count", {24'h0, base[7:0] + 8'h01}, word);
      rd(REG_ANOM_COUNT);
      chk_word("anom_count", 32'(n + 1), word);
      @(posedge mclk);
      power_ok_pin <= 1'b0;
      repeat (4) @(negedge mclk);
      chk_bit("power_status_bit", 1'b0, power_status_bit);
      // loss frames are counted once power is back, so a short dip still sends three
      @(posedge mclk);
      power_ok_pin <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         repeat (4) @(negedge mclk);
         chk_bit("power_status_bit", 1'b0, power_status_bit);
         @(posedge mclk);
         tx_frame_start <= 1'b1;
         @(posedge mclk);
         tx_frame_start <= 1'b0;
      end
      repeat (2) @(negedge mclk);
      chk_bit("power_status_bit", 1'b1, power_status_bit);
      stop_test();
   end
endmodule
